// >>> gps_pkg.sv
// Constants for the generator protection supervisor.
// Assumes a 200 MHz system clock and a 10 ms protection tick.
package gps_pkg;
  // Clock and time base
  localparam int CLK_HZ      = 200_000_000;
  localparam int TICK_MS     = 10;
  localparam int TICK_CYC    = CLK_HZ / 1000 * TICK_MS;
  localparam int TICKS_PER_S = 1000 / TICK_MS;
  localparam int DLY_SCALE   = 100 / TICK_MS;
  localparam int OV_DLY_MS   = 750;
  localparam int OV_DLY_TCK  = OV_DLY_MS / TICK_MS;
  localparam int FLASH_MS    = 15000;
  localparam int FLASH_TCK   = FLASH_MS / TICK_MS;
  // Soft start ramp resolution
  localparam int SS_SHIFT    = 6;
  localparam int SS_STEPS    = 1 << SS_SHIFT;
  // Droop: 0.1 % units times reactive units of 100 at rated
  localparam int DROOP_DEN   = 100000;
  localparam int DROOP_MAX   = 100;
  // Register byte offsets
  localparam logic [7:0] A_CTRL   = 8'h00;
  localparam logic [7:0] A_SETPT  = 8'h04;
  localparam logic [7:0] A_DROOP  = 8'h08;
  localparam logic [7:0] A_SSTIME = 8'h0c;
  localparam logic [7:0] A_OEXLVL = 8'h10;
  localparam logic [7:0] A_OEXDLY = 8'h14;
  localparam logic [7:0] A_OVPCT  = 8'h18;
  localparam logic [7:0] A_UVPCT  = 8'h1c;
  localparam logic [7:0] A_UVDLY  = 8'h20;
  localparam logic [7:0] A_IMBDLY = 8'h24;
  localparam logic [7:0] A_STATUS = 8'h28;
  localparam logic [7:0] A_HIST   = 8'h2c;
  // Reset values and limits
  localparam logic [15:0] R_CTRL   = 16'h0001;
  localparam logic [15:0] R_SETPT  = 16'h1000;
  localparam logic [15:0] R_DROOP  = 16'h0032;
  localparam logic [15:0] R_SSTIME = 16'h0003;
  localparam logic [15:0] L_SSTIME = 16'h0002;
  localparam logic [15:0] H_SSTIME = 16'h0078;
  localparam logic [15:0] R_OEXLVL = 16'h0dac;
  localparam logic [15:0] L_OEXLVL = 16'h01f4;
  localparam logic [15:0] H_OEXLVL = 16'h0fa0;
  localparam logic [15:0] R_OEXDLY = 16'h0096;
  localparam logic [15:0] R_UVDLY  = 16'h003c;
  localparam logic [15:0] R_IMBDLY = 16'h0078;
  localparam logic [15:0] L_DLY    = 16'h000a;
  localparam logic [15:0] H_DLY    = 16'h0096;
  localparam logic [15:0] R_OVPCT  = 16'h0014;
  localparam logic [15:0] L_OVPCT  = 16'h0005;
  localparam logic [15:0] H_OVPCT  = 16'h0014;
  localparam logic [15:0] R_UVPCT  = 16'h0019;
  localparam logic [15:0] L_UVPCT  = 16'h0005;
  localparam logic [15:0] H_UVPCT  = 16'h0032;
  // Regulation modes
  localparam logic [1:0] MODE_SGL = 2'h0;
  localparam logic [1:0] MODE_TRI = 2'h1;
  localparam logic [1:0] MODE_FLD = 2'h2;
  // Timed protection functions
  localparam int F_OEX = 0;
  localparam int F_OV  = 1;
  localparam int F_UV  = 2;
  localparam int F_IMB = 3;
  localparam int N_TMD = 4;
  // Synchronised pin positions
  localparam int P_SPD = 0;
  localparam int P_SNS = 1;
  localparam int P_IMB = 2;
  localparam int P_UV  = 3;
  localparam int P_OV  = 4;
  localparam int P_B90 = 5;
  localparam int P_OEX = 6;
  localparam int P_EXO = 7;
  localparam int P_DRO = 8;
  localparam int N_PIN = 9;
  // Display codes
  localparam logic [3:0] C_RUN     = 4'h0;
  localparam logic [3:0] C_OEX_ALM = 4'h1;
  localparam logic [3:0] C_UV_ALM  = 4'h2;
  localparam logic [3:0] C_IMB_ALM = 4'h3;
  localparam logic [3:0] C_OEX_FLT = 4'h4;
  localparam logic [3:0] C_OV_FLT  = 4'h5;
  localparam logic [3:0] C_UV_FLT  = 4'h6;
  localparam logic [3:0] C_IMB_FLT = 4'h7;
  localparam logic [3:0] C_SNS_FLT = 4'h8;
  // Protection state, one-hot
  typedef enum logic [2:0] {
    GPS_RUN   = 3'b001,
    GPS_ALARM = 3'b010,
    GPS_FAULT = 3'b100
  } gps_prot_t;
endpackage : gps_pkg

// >>> gps_supervisor.sv
// Generator protection supervisor: droop, soft start and shutdowns.
// Assumes a Wishbone classic master and comparator flags on pins.
//
// Behaviour
// - droop lowers set point lagging, raises leading
// - droop gain configurable up to 10 percent at rated
// - single-phase sensing uses average phase current
// - soft start ramp 2 to 120 s
// - ramp only in voltage regulation modes
// - under-frequency adjustment overrides the ramp
// - over-excitation level and delay configurable
// - over-excitation starts timer, shows alarm code
// - still above 90 percent at expiry trips
// - faults latch until power loss or inhibit
// - inhibit release flashes dotted code after over-excitation, over-voltage or under-voltage; history records faults as they latch
// - over-voltage trips after fixed 0.75 s
// - under-voltage level, delay, alarm and timer
// - under-voltage persisting whole delay trips
// - no under-voltage protection in field mode
// - imbalance starts configurable delay and alarm
// - imbalance protection only in three-phase mode
// - imbalance persisting whole delay trips
// - sensing loss trips at once, no alarm
// - sensing loss waits for 850 rpm, except in field mode
// - droop applied only while contact open
// - inhibit holds excitation off, release restarts
// - fault contact closes only on shutdown
`timescale 1ns/1ps
module gps_supervisor #(
  parameter int TICK_CYC = gps_pkg::TICK_CYC
) (
  // Clock, reset, enable
  input  wire logic               clk,
  input  wire logic               nrst,
  input  wire logic               ce,
  // Wishbone slave
  input  wire logic               wb_cyc_i,
  input  wire logic               wb_stb_i,
  input  wire logic               wb_we_i,
  input  wire logic [7:0]         wb_adr_i,
  input  wire logic [3:0]         wb_sel_i,
  input  wire logic [31:0]        wb_dat_i,
  output logic      [31:0]        wb_dat_o,
  output logic                    wb_ack_o,
  // Contacts and front end flags
  input  wire logic               droop_off_closed,
  input  wire logic               exc_off_closed,
  input  wire logic               oex_above,
  input  wire logic               oex_below90,
  input  wire logic               ov_above,
  input  wire logic               uv_below,
  input  wire logic               imb_detect,
  input  wire logic               sense_lost,
  input  wire logic               speed_850,
  // Same-clock regulation inputs
  input  wire logic signed [7:0]  iq_tri,
  input  wire logic signed [7:0]  iq_a,
  input  wire logic signed [7:0]  iq_b,
  input  wire logic signed [7:0]  iq_c,
  input  wire logic               uf_active,
  input  wire logic [15:0]        uf_setpoint,
  // Outputs to regulator, field driver and display
  output logic      [15:0]        setpoint_o,
  output logic                    exc_en_o,
  output logic                    fault_contact_o,
  output logic      [3:0]         disp_code_o,
  output logic                    disp_dot_o,
  output logic      [11:0]        oex_level_o,
  output logic      [4:0]         ov_pct_o,
  output logic      [5:0]         uv_pct_o
);

  // Byte-lane merge of a 16-bit register
  function automatic logic [15:0] merge(input logic [15:0] old,
                                        input logic [31:0] d,
                                        input logic [3:0]  s);
    merge = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
  endfunction : merge

  // Limit a written value to its legal range
  function automatic logic [15:0] clamp(input logic [15:0] v,
                                        input logic [15:0] lo,
                                        input logic [15:0] hi);
    clamp = (v < lo) ? lo : ((v > hi) ? hi : v);
  endfunction : clamp

  // Pin synchronisers
  logic [gps_pkg::N_PIN-1:0] sync1_r;
  logic [gps_pkg::N_PIN-1:0] pin_r;
  logic                      exo_d_r;
  wire  [gps_pkg::N_PIN-1:0] pins = {droop_off_closed, exc_off_closed,
                                     oex_above, oex_below90, ov_above,
                                     uv_below, imb_detect, sense_lost,
                                     speed_850};

  always_ff @(posedge clk) begin
    if (!nrst) begin
      sync1_r <= '0;
      pin_r   <= '0;
      exo_d_r <= 1'b0;
    end else if (ce) begin
      sync1_r <= pins;
      pin_r   <= sync1_r;
      exo_d_r <= pin_r[gps_pkg::P_EXO];
    end
  end

  wire exo = pin_r[gps_pkg::P_EXO];
  wire rel = exo_d_r & ~exo;

  // Registers
  logic [15:0] ctrl_r, setpt_r, droop_r, sstime_r, oexlvl_r, oexdly_r;
  logic [15:0] ovpct_r, uvpct_r, uvdly_r, imbdly_r;
  logic [4:0]  hist_r;
  logic        ack_r;
  logic [31:0] dat_r;

  wire        acc  = wb_cyc_i & wb_stb_i & ~ack_r;
  wire        wr   = acc & wb_we_i;
  wire [1:0]  mode = ctrl_r[1:0];
  wire        sgl_i = ctrl_r[2];
  wire        vmode = (mode == gps_pkg::MODE_SGL) |
                      (mode == gps_pkg::MODE_TRI);

  // Register writes
  always_ff @(posedge clk) begin
    if (!nrst) begin
      ctrl_r   <= gps_pkg::R_CTRL;
      setpt_r  <= gps_pkg::R_SETPT;
      droop_r  <= gps_pkg::R_DROOP;
      sstime_r <= gps_pkg::R_SSTIME;
      oexlvl_r <= gps_pkg::R_OEXLVL;
      oexdly_r <= gps_pkg::R_OEXDLY;
      ovpct_r  <= gps_pkg::R_OVPCT;
      uvpct_r  <= gps_pkg::R_UVPCT;
      uvdly_r  <= gps_pkg::R_UVDLY;
      imbdly_r <= gps_pkg::R_IMBDLY;
    end else if (ce && wr) begin
      unique case (wb_adr_i)
        gps_pkg::A_CTRL:   ctrl_r  <= merge(ctrl_r, wb_dat_i, wb_sel_i);
        gps_pkg::A_SETPT:  setpt_r <= merge(setpt_r, wb_dat_i, wb_sel_i);
        gps_pkg::A_DROOP:  droop_r <= clamp(merge(droop_r, wb_dat_i,
                                      wb_sel_i), '0, 16'(gps_pkg::DROOP_MAX));
        gps_pkg::A_SSTIME: sstime_r <= clamp(merge(sstime_r, wb_dat_i,
                                       wb_sel_i), gps_pkg::L_SSTIME,
                                       gps_pkg::H_SSTIME);
        gps_pkg::A_OEXLVL: oexlvl_r <= clamp(merge(oexlvl_r, wb_dat_i,
                                       wb_sel_i), gps_pkg::L_OEXLVL,
                                       gps_pkg::H_OEXLVL);
        gps_pkg::A_OEXDLY: oexdly_r <= clamp(merge(oexdly_r, wb_dat_i,
                                       wb_sel_i), gps_pkg::L_DLY,
                                       gps_pkg::H_DLY);
        gps_pkg::A_OVPCT:  ovpct_r <= clamp(merge(ovpct_r, wb_dat_i,
                                      wb_sel_i), gps_pkg::L_OVPCT,
                                      gps_pkg::H_OVPCT);
        gps_pkg::A_UVPCT:  uvpct_r <= clamp(merge(uvpct_r, wb_dat_i,
                                      wb_sel_i), gps_pkg::L_UVPCT,
                                      gps_pkg::H_UVPCT);
        gps_pkg::A_UVDLY:  uvdly_r <= clamp(merge(uvdly_r, wb_dat_i,
                                      wb_sel_i), gps_pkg::L_DLY,
                                      gps_pkg::H_DLY);
        gps_pkg::A_IMBDLY: imbdly_r <= clamp(merge(imbdly_r, wb_dat_i,
                                       wb_sel_i), gps_pkg::L_DLY,
                                       gps_pkg::H_DLY);
        default: ;
      endcase
    end
  end

  // Protection time base
  logic [31:0] pre_r;
  logic        tick_r;

  always_ff @(posedge clk) begin
    if (!nrst) begin
      pre_r  <= '0;
      tick_r <= 1'b0;
    end else if (ce) begin
      tick_r <= (pre_r == 32'(TICK_CYC - 1));
      pre_r  <= (pre_r == 32'(TICK_CYC - 1)) ? '0 : pre_r + 32'h1;
    end
  end

  // Timed protection conditions
  logic [gps_pkg::N_TMD-1:0] alm, flt, start_c, hold_c;
  logic [15:0]               dly [gps_pkg::N_TMD];

  assign start_c[gps_pkg::F_OEX] = pin_r[gps_pkg::P_OEX];
  assign hold_c[gps_pkg::F_OEX]  = ~pin_r[gps_pkg::P_B90];
  assign start_c[gps_pkg::F_OV]  = pin_r[gps_pkg::P_OV];
  assign hold_c[gps_pkg::F_OV]   = pin_r[gps_pkg::P_OV];
  assign start_c[gps_pkg::F_UV]  = pin_r[gps_pkg::P_UV] & vmode;
  assign hold_c[gps_pkg::F_UV]   = pin_r[gps_pkg::P_UV] & vmode;
  assign start_c[gps_pkg::F_IMB] = pin_r[gps_pkg::P_IMB] &
                                   (mode == gps_pkg::MODE_TRI);
  assign hold_c[gps_pkg::F_IMB]  = start_c[gps_pkg::F_IMB];

  assign dly[gps_pkg::F_OEX] = 16'(oexdly_r * gps_pkg::DLY_SCALE);
  assign dly[gps_pkg::F_OV]  = 16'(gps_pkg::OV_DLY_TCK);
  assign dly[gps_pkg::F_UV]  = 16'(uvdly_r * gps_pkg::DLY_SCALE);
  assign dly[gps_pkg::F_IMB] = 16'(imbdly_r * gps_pkg::DLY_SCALE);

  for (genvar i = 0; i < gps_pkg::N_TMD; i++) begin : g_prot
    gps_pkg::gps_prot_t st_r;
    logic [15:0]        cnt_r;

    always_ff @(posedge clk) begin
      if (!nrst) begin
        st_r  <= gps_pkg::GPS_RUN;
        cnt_r <= '0;
      end else if (ce) begin
        unique case (st_r)
          gps_pkg::GPS_RUN: begin
            cnt_r <= '0;
            if (start_c[i] && !exo) begin
              st_r <= gps_pkg::GPS_ALARM;
            end
          end
          gps_pkg::GPS_ALARM: begin
            if (!hold_c[i] || exo) begin
              st_r  <= gps_pkg::GPS_RUN;
              cnt_r <= '0;
            end else if (tick_r) begin
              if (cnt_r + 16'h1 >= dly[i]) begin
                st_r <= gps_pkg::GPS_FAULT;
              end
              cnt_r <= cnt_r + 16'h1;
            end
          end
          gps_pkg::GPS_FAULT: begin
            if (rel) begin
              st_r <= gps_pkg::GPS_RUN;
            end
          end
        endcase
      end
    end

    assign alm[i] = (st_r == gps_pkg::GPS_ALARM);
    assign flt[i] = (st_r == gps_pkg::GPS_FAULT);
  end

  // Sensing loss latch
  logic spd_seen_r, sns_r;
  wire  sns_en  = (mode == gps_pkg::MODE_FLD) | spd_seen_r;
  wire  sns_set = pin_r[gps_pkg::P_SNS] & sns_en & ~exo;

  always_ff @(posedge clk) begin
    if (!nrst) begin
      spd_seen_r <= 1'b0;
      sns_r      <= 1'b0;
    end else if (ce) begin
      spd_seen_r <= spd_seen_r | pin_r[gps_pkg::P_SPD];
      sns_r <= sns_set | (sns_r & ~rel);
    end
  end

  wire [4:0] flt_all = {sns_r, flt};
  wire       any_flt = |flt_all;

  // Flash after release, fault history
  logic [3:0]  fl_code_r;
  logic [15:0] fl_cnt_r;
  wire  [3:0]  rel_code = flt[gps_pkg::F_OEX] ? gps_pkg::C_OEX_FLT :
                          flt[gps_pkg::F_OV]  ? gps_pkg::C_OV_FLT  :
                          gps_pkg::C_UV_FLT;
  wire         rel_fl   = rel & (flt[gps_pkg::F_OEX] | flt[gps_pkg::F_OV] |
                          flt[gps_pkg::F_UV]);
  wire         hist_clr = wr & (wb_adr_i == gps_pkg::A_HIST) & wb_sel_i[0];

  always_ff @(posedge clk) begin
    if (!nrst) begin
      fl_code_r <= gps_pkg::C_RUN;
      fl_cnt_r  <= '0;
      hist_r    <= '0;
    end else if (ce) begin
      if (rel_fl) begin
        fl_code_r <= rel_code;
        fl_cnt_r  <= 16'(gps_pkg::FLASH_TCK);
      end else if (tick_r && fl_cnt_r != '0) begin
        fl_cnt_r <= fl_cnt_r - 16'h1;
      end
      hist_r <= flt_all | (hist_r & ~(hist_clr ? wb_dat_i[4:0] : 5'h00));
    end
  end

  // Display selection
  wire [3:0] disp_nxt =
    flt[gps_pkg::F_OEX] ? gps_pkg::C_OEX_FLT :
    flt[gps_pkg::F_OV]  ? gps_pkg::C_OV_FLT  :
    flt[gps_pkg::F_UV]  ? gps_pkg::C_UV_FLT  :
    flt[gps_pkg::F_IMB] ? gps_pkg::C_IMB_FLT :
    sns_r               ? gps_pkg::C_SNS_FLT :
    (fl_cnt_r != '0)    ? fl_code_r          :
    alm[gps_pkg::F_OEX] ? gps_pkg::C_OEX_ALM :
    alm[gps_pkg::F_UV]  ? gps_pkg::C_UV_ALM  :
    alm[gps_pkg::F_IMB] ? gps_pkg::C_IMB_ALM : gps_pkg::C_RUN;
  wire       dot_nxt  = ~any_flt & (fl_cnt_r != '0);

  // Droop computation
  wire signed [9:0]  iq_sum = 10'(iq_a) + 10'(iq_b) + 10'(iq_c);
  wire signed [9:0]  iq_sel = sgl_i ? iq_sum / 10'sd3 : 10'(iq_tri);
  wire               droop_on = ~pin_r[gps_pkg::P_DRO];
  wire signed [35:0] dprod = $signed({1'b0, setpt_r}) *
                             $signed({1'b0, droop_r[7:0]}) * iq_sel;
  wire signed [17:0] doff = droop_on ?
                            18'(dprod / 36'sd100000) : 18'sd0;
  wire signed [18:0] tgt_s = $signed({3'b000, setpt_r}) - 19'(doff);
  wire [15:0]        tgt = tgt_s[18] ? 16'h0000 :
                           (|tgt_s[17:16]) ? 16'hffff : tgt_s[15:0];

  // Soft start ramp
  logic [6:0]  prog_r;
  logic [15:0] err_r;
  wire  [15:0] span = 16'(sstime_r * gps_pkg::TICKS_PER_S);
  wire  [15:0] err_a = err_r + 16'(gps_pkg::SS_STEPS);
  wire  [22:0] ramp_p = tgt * prog_r;
  wire  [15:0] ramp = ramp_p[gps_pkg::SS_SHIFT +: 16];

  always_ff @(posedge clk) begin
    if (!nrst) begin
      prog_r <= '0;
      err_r  <= '0;
    end else if (ce) begin
      if (exo) begin
        prog_r <= '0;
        err_r  <= '0;
      end else if (tick_r && prog_r < 7'(gps_pkg::SS_STEPS)) begin
        if (err_a >= span) begin
          prog_r <= prog_r + 7'h1;
          err_r  <= err_a - span;
        end else begin
          err_r <= err_a;
        end
      end
    end
  end

  wire [15:0] sp_v   = (vmode && prog_r < 7'(gps_pkg::SS_STEPS)) ? ramp : tgt;
  wire [15:0] sp_nxt = uf_active ? uf_setpoint : sp_v;

  // Outputs
  always_ff @(posedge clk) begin
    if (!nrst) begin
      setpoint_o      <= '0;
      exc_en_o        <= 1'b0;
      fault_contact_o <= 1'b0;
      disp_code_o     <= gps_pkg::C_RUN;
      disp_dot_o      <= 1'b0;
      oex_level_o     <= '0;
      ov_pct_o        <= '0;
      uv_pct_o        <= '0;
    end else if (ce) begin
      setpoint_o      <= sp_nxt;
      exc_en_o        <= ~exo & ~any_flt;
      fault_contact_o <= any_flt;
      disp_code_o     <= disp_nxt;
      disp_dot_o      <= dot_nxt;
      oex_level_o     <= oexlvl_r[11:0];
      ov_pct_o        <= ovpct_r[4:0];
      uv_pct_o        <= uvpct_r[5:0];
    end
  end

  // Bus read and acknowledge
  wire [15:0] stat = {3'h0, droop_on, exo, alm, flt_all, disp_nxt[1:0]};
  wire [15:0] rd =
    (wb_adr_i == gps_pkg::A_CTRL)   ? ctrl_r   :
    (wb_adr_i == gps_pkg::A_SETPT)  ? setpt_r  :
    (wb_adr_i == gps_pkg::A_DROOP)  ? droop_r  :
    (wb_adr_i == gps_pkg::A_SSTIME) ? sstime_r :
    (wb_adr_i == gps_pkg::A_OEXLVL) ? oexlvl_r :
    (wb_adr_i == gps_pkg::A_OEXDLY) ? oexdly_r :
    (wb_adr_i == gps_pkg::A_OVPCT)  ? ovpct_r  :
    (wb_adr_i == gps_pkg::A_UVPCT)  ? uvpct_r  :
    (wb_adr_i == gps_pkg::A_UVDLY)  ? uvdly_r  :
    (wb_adr_i == gps_pkg::A_IMBDLY) ? imbdly_r :
    (wb_adr_i == gps_pkg::A_STATUS) ? stat     :
    (wb_adr_i == gps_pkg::A_HIST)   ? {11'h000, hist_r} : 16'h0000;

  assign ack_r = wb_ack_o;

  always_ff @(posedge clk) begin
    if (!nrst) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= '0;
    end else if (ce) begin
      wb_ack_o <= acc;
      wb_dat_o <= acc ? {16'h0000, rd} : wb_dat_o;
    end
  end

endmodule : gps_supervisor

// >>> gps_supervisor_chk.sv
// Port checker for the generator protection supervisor.
// Bound to every gps_supervisor; sees its ports only.
`timescale 1ns/1ps
module gps_supervisor_chk #(
  parameter int TICK_CYC = gps_pkg::TICK_CYC
) (
  // Clock and reset
  input wire logic       clk,
  input wire logic       nrst,
  // Watched inputs
  input wire logic       exc_off_closed,
  input wire logic       oex_above,
  input wire logic       oex_below90,
  input wire logic       ov_above,
  input wire logic       uv_below,
  input wire logic       imb_detect,
  input wire logic       sense_lost,
  input wire logic       speed_850,
  // Watched outputs
  input wire logic       wb_ack_o,
  input wire logic       exc_en_o,
  input wire logic       fault_contact_o,
  input wire logic [3:0] disp_code_o,
  input wire logic       disp_dot_o
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  chk_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held over one cycle");
  chk_trip_exc: assert property (fault_contact_o |-> !exc_en_o)
    else $error("excitation on with contact closed");
  chk_trip_code: assert property (
    fault_contact_o |-> disp_code_o >= gps_pkg::C_OEX_FLT)
    else $error("contact closed without fault code");
  chk_alarm_open: assert property (
    disp_code_o inside {[gps_pkg::C_OEX_ALM:gps_pkg::C_IMB_ALM]} |-> !fault_contact_o)
    else $error("contact closed during alarm");
  chk_sense_trip: assert property (
    (sense_lost && speed_850 && !exc_off_closed)[*6] |-> fault_contact_o)
    else $error("sensing loss did not trip");
  chk_fault_latch: assert property (
    (!exc_off_closed)[*6] ##0 fault_contact_o |=> fault_contact_o)
    else $error("fault dropped without inhibit");
  chk_inhibit_off: assert property (exc_off_closed[*5] |-> !exc_en_o)
    else $error("excitation on while inhibited");
  chk_ov_delay: assert property (
    $rose(ov_above) && !fault_contact_o && !oex_above && oex_below90 && !uv_below
      && !imb_detect && !sense_lost |=> (!fault_contact_o)[*8])
    else $error("over-voltage tripped without delay");
  chk_dot_code: assert property (
    disp_dot_o |-> disp_code_o inside {[gps_pkg::C_OEX_FLT:gps_pkg::C_UV_FLT]})
    else $error("dotted code on wrong function");
  cover property ($rose(fault_contact_o));
  cover property ($rose(disp_dot_o));
  cover property (disp_code_o == gps_pkg::C_OEX_ALM);
endmodule : gps_supervisor_chk

bind gps_supervisor gps_supervisor_chk #(.TICK_CYC(TICK_CYC)) u_chk (.*);

// >>> gps_front_end.sv
// Sensing front end and field driver model: comparator flags.
// Knobs come from the bench; thresholds from the supervisor.
`timescale 1ns/1ps
module gps_front_end (
  // Clock and knobs
  input wire logic              clk,
  input wire logic [11:0]       i_set,
  input wire logic signed [7:0] v_dev,
  // Thresholds and field enable
  input wire logic              exc_en_o,
  input wire logic [11:0]       oex_level_o,
  input wire logic [4:0]        ov_pct_o,
  input wire logic [5:0]        uv_pct_o,
  // Comparator flags
  output logic                  oex_above,
  output logic                  oex_below90,
  output logic                  ov_above,
  output logic                  uv_below
);
  logic [11:0] i_fld;
  // Field current flows only while excited
  assign i_fld = exc_en_o ? i_set : 12'h000;
  always_ff @(posedge clk) begin
    oex_above   <= i_fld > oex_level_o;
    oex_below90 <= 17'(i_fld) * 10 < 17'(oex_level_o) * 9;
    ov_above    <= v_dev > $signed({3'h0, ov_pct_o});
    uv_below    <= -v_dev > $signed({2'h0, uv_pct_o});
  end
endmodule : gps_front_end

// >>> gps_supervisor_bench.sv
// Self-checking bench of the supervisor beside the front end model.
// Runs alone; the checker is bound in from its own file.
`timescale 1ns/1ps
module gps_supervisor_bench;
  localparam int TK = 4;
  localparam logic [15:0] DRP = 16'(32'(gps_pkg::R_SETPT) * gps_pkg::R_DROOP
                                    * 100 / gps_pkg::DROOP_DEN);
  typedef struct {logic [7:0] a; logic w; logic [15:0] d, e;} gps_row_t;
  logic clk = 0, nrst = 0, ce = 1, uf_active = 0, wb_cyc_i = 0, wb_stb_i = 0;
  logic wb_we_i = 0, droop_off_closed = 0, exc_off_closed = 0, imb_detect = 0;
  logic sense_lost = 0, speed_850 = 0, wb_ack_o, exc_en_o, fault_contact_o;
  logic disp_dot_o, oex_above, oex_below90, ov_above, uv_below;
  logic signed [7:0] iq_tri = '0, v_dev = '0, iq_a, iq_b, iq_c;
  logic [7:0]  wb_adr_i = '0;
  logic [3:0]  wb_sel_i = '0, disp_code_o;
  logic [31:0] wb_dat_i = '0, wb_dat_o, q;
  logic [15:0] uf_setpoint = '0, setpoint_o;
  logic [11:0] i_set = '0, oex_level_o;
  logic [4:0]  ov_pct_o;
  logic [5:0]  uv_pct_o;
  int          errors = 0, n_tests = 0, cycles = 0, i;
  gps_row_t rows [12] = '{
    '{gps_pkg::A_CTRL, 0, 0, gps_pkg::R_CTRL}, '{gps_pkg::A_DROOP, 0, 0, gps_pkg::R_DROOP},
    '{gps_pkg::A_SSTIME, 0, 0, gps_pkg::R_SSTIME}, '{gps_pkg::A_OEXLVL, 0, 0, gps_pkg::R_OEXLVL},
    '{gps_pkg::A_OEXDLY, 0, 0, gps_pkg::R_OEXDLY}, '{gps_pkg::A_OVPCT, 0, 0, gps_pkg::R_OVPCT},
    '{gps_pkg::A_UVPCT, 0, 0, gps_pkg::R_UVPCT}, '{gps_pkg::A_IMBDLY, 0, 0, gps_pkg::R_IMBDLY},
    '{gps_pkg::A_SSTIME, 1, 1, gps_pkg::L_SSTIME}, '{gps_pkg::A_OEXDLY, 1, 0, gps_pkg::L_DLY},
    '{gps_pkg::A_OVPCT, 1, 16'h001f, gps_pkg::H_OVPCT}, '{8'h30, 1, 16'hffff, 0}};

  assign iq_a = iq_tri;
  assign iq_b = iq_tri;
  assign iq_c = iq_tri;
  gps_supervisor #(.TICK_CYC(TK)) uut (.*);
  gps_front_end u_fe (.*);
  always #2.5 clk = ~clk;

  task automatic tk(input int n);
    repeat (n) @(posedge clk);
  endtask : tk

  task automatic wb(input logic w, input logic [7:0] a, input logic [15:0] d);
    @(posedge clk);
    wb_cyc_i <= 1;
    wb_stb_i <= 1;
    wb_we_i  <= w;
    wb_adr_i <= a;
    wb_sel_i <= 4'h3;
    wb_dat_i <= {16'h0000, d};
    @(posedge clk);
    while (wb_ack_o !== 1'b1) @(posedge clk);
    q = wb_dat_o;
    wb_cyc_i <= 0;
    wb_stb_i <= 0;
  endtask : wb

  task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      errors++;
      $display("unexpected %s: expected %h, seen %h", s, e, g);
    end
  endtask : chk

  task automatic pulse();
    exc_off_closed <= 1;
    tk(10);
    exc_off_closed <= 0;
    tk(10);
  endtask : pulse

  task automatic end_of_test();
    $display("checks %0d, mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : end_of_test

  always @(posedge clk) begin
    cycles++;
    if (cycles == 12000) begin
      errors++;
      end_of_test();
    end
  end

  initial begin
    tk(4);
    nrst <= 1;
    foreach (rows[k]) begin
      if (rows[k].w) wb(1, rows[k].a, rows[k].d);
      wb(0, rows[k].a, 16'h0000);
      chk("register", {16'h0000, rows[k].e}, q);
    end
    $display("test registers finished");
    for (i = 0; i < 3000 && setpoint_o !== gps_pkg::R_SETPT; i++) tk(1);
    chk("ramp end", gps_pkg::R_SETPT, setpoint_o);
    iq_tri <= 8'sd100;
    tk(10);
    chk("lagging set point", gps_pkg::R_SETPT - DRP, setpoint_o);
    iq_tri <= -8'sd100;
    tk(10);
    chk("leading set point", gps_pkg::R_SETPT + DRP, setpoint_o);
    droop_off_closed <= 1;
    tk(10);
    chk("droop off", gps_pkg::R_SETPT, setpoint_o);
    $display("test droop finished");
    sense_lost <= 1;
    tk(20);
    chk("contact before speed", 0, fault_contact_o);
    speed_850 <= 1;
    tk(6);
    chk("sensing code", gps_pkg::C_SNS_FLT, disp_code_o);
    sense_lost <= 0;
    tk(20);
    chk("latched contact", 1, fault_contact_o);
    pulse();
    chk("cleared", 0, {disp_dot_o, fault_contact_o, disp_code_o});
    wb(1, gps_pkg::A_CTRL, {14'h0000, gps_pkg::MODE_FLD});
    v_dev <= -8'sd30;
    tk(20);
    chk("uv in field mode", gps_pkg::C_RUN, disp_code_o);
    wb(1, gps_pkg::A_CTRL, {14'h0000, gps_pkg::MODE_SGL});
    tk(10);
    chk("uv alarm", gps_pkg::C_UV_ALM, disp_code_o);
    v_dev <= 0;
    imb_detect <= 1;
    tk(20);
    chk("imbalance single", gps_pkg::C_RUN, disp_code_o);
    wb(1, gps_pkg::A_CTRL, {14'h0000, gps_pkg::MODE_TRI});
    tk(10);
    chk("imbalance alarm", gps_pkg::C_IMB_ALM, disp_code_o);
    imb_detect <= 0;
    tk(10);
    chk("back to run", gps_pkg::C_RUN, disp_code_o);
    $display("test sensing and modes finished");
    v_dev <= 8'sd25;
    tk(280);
    chk("ov early", 0, fault_contact_o);
    tk(40);
    chk("ov fault", gps_pkg::C_OV_FLT, disp_code_o);
    v_dev <= 0;
    pulse();
    chk("ov dotted", {1'b1, gps_pkg::C_OV_FLT}, {disp_dot_o, disp_code_o});
    tk(gps_pkg::FLASH_TCK * TK + 10);
    chk("flash over", 0, disp_dot_o);
    $display("test over-voltage finished");
    i_set <= 12'd4000;
    tk(10);
    chk("oex alarm", gps_pkg::C_OEX_ALM, disp_code_o);
    i_set <= 0;
    tk(10);
    chk("oex cleared", gps_pkg::C_RUN, disp_code_o);
    i_set <= 12'd4000;
    tk(380);
    chk("oex early", 0, fault_contact_o);
    tk(40);
    chk("oex fault", {1'b1, gps_pkg::C_OEX_FLT}, {fault_contact_o, disp_code_o});
    i_set <= 0;
    pulse();
    chk("oex dotted", {1'b1, gps_pkg::C_OEX_FLT}, {disp_dot_o, disp_code_o});
    wb(1, gps_pkg::A_IMBDLY, 16'h0000);
    imb_detect <= 1;
    tk(420);
    chk("imb fault", gps_pkg::C_IMB_FLT, disp_code_o);
    imb_detect <= 0;
    pulse();
    wb(1, gps_pkg::A_UVDLY, 16'h0000);
    v_dev <= -8'sd30;
    tk(420);
    chk("uv fault", gps_pkg::C_UV_FLT, disp_code_o);
    $display("test over-excitation finished");
    end_of_test();
  end
endmodule : gps_supervisor_bench
